// ===== shared/rwc_pkg.sv
// Package of constants and types for the reset, watchdog and wakeup control block
// Contract
// [RULE1] Leaving reset, fetch starts at 3FFD where a jump opcode BC is expected.
// [RULE2] Software image must hold a jump and two-byte target at the fetch location.
// [RULE3] Reset forces registers to defaults, disables peripherals, pins high-impedance, pulls off.
// [RULE4] Seven reset sources; each except the debug-forced one has a cause flag.
// [RULE5] External reset pin acts only while reset pin enable is set.
// [RULE6] Any reset sets watchdog enable; clearing it stops watchdog resets.
// [RULE7] Any write to the cause address clears the watchdog, flags unchanged.
// [RULE8] Period select 0 gives 2^5 counts, 1 gives 2^8; long is default.
// [RULE9] Watchdog advances on the independent 1 kHz source, one count per millisecond.
// [RULE10] Watchdog reaching its overflow count resets the system and sets its flag.
// [RULE11] First option register write after reset also clears the watchdog.
// [RULE12] In background debug mode the watchdog counter holds.
// [RULE13] Stop entry zeroes the watchdog; counting restarts from zero on stop exit.
// [RULE14] No vectored dispatch; enabled requests only wake the core from wait or stop.
// [RULE15] A disabled source cannot wake, but its event flag still sets.
// [RULE16] Wake pending register shows one read-only bit per module; writes ignored.
// [RULE17] A module's pending bit clears once all its flags are clear.
// [RULE18] Low-voltage detector runs only when enabled; off in stop unless stop-enabled.
// [RULE19] After power-on, hold reset until supply adequate; set power-on and low-voltage flags.
// [RULE20] With low-voltage reset enabled, detection resets and holds until recovery; flag set.
// [RULE21] A debug-forced reset clears every cause flag.
// [RULE22] Option register takes only its first write after reset; always readable.
// [RULE23] Stop instruction with stop disabled acts as an illegal-opcode reset.
// [RULE24] Cause flags latch at reset entry from active sources, stable until next reset.
package rwc_pkg;

  localparam int unsigned AW       = 8;
  localparam int unsigned DW       = 8;
  localparam int unsigned NMOD     = 5;
  localparam int unsigned FPM      = 2;
  localparam int unsigned VEC_W    = 14;

  localparam logic [AW-1:0] OFS_CAUSE = 8'h00;
  localparam logic [AW-1:0] OFS_OPT   = 8'h01;
  localparam logic [AW-1:0] OFS_PM    = 8'h02;
  localparam logic [AW-1:0] OFS_PEND  = 8'h03;

  localparam int unsigned CS_POR  = 7;
  localparam int unsigned CS_PIN  = 6;
  localparam int unsigned CS_WDOG = 5;
  localparam int unsigned CS_ILLEGAL_OPCODE_RESET = 4;
  localparam int unsigned CS_ILLEGAL_ADDRESS_RESET = 3;
  localparam int unsigned CS_LVD  = 1;

  localparam int unsigned OPT_WEN  = 7;
  localparam int unsigned OPT_WPS  = 6;
  localparam int unsigned OPT_STOP = 5;
  localparam int unsigned OPT_PIN  = 0;
  localparam logic [DW-1:0] OPT_RST  = 8'hC0;
  localparam logic [DW-1:0] OPT_MASK = 8'hE1;

  localparam int unsigned PM_LVEN  = 2;
  localparam int unsigned PM_LVSE  = 1;
  localparam int unsigned PM_LVRE  = 0;
  localparam logic [DW-1:0] PM_RST  = 8'h05;
  localparam logic [DW-1:0] PM_MASK = 8'h07;

  localparam logic [VEC_W-1:0] RESET_VEC   = 14'h3FFD;
  localparam logic [DW-1:0]    JMP_OPCODE  = 8'hBC;

  localparam int unsigned WD_W       = 9;
  localparam logic [WD_W-1:0] WD_SHORT = 9'h020;
  localparam logic [WD_W-1:0] WD_LONG  = 9'h100;

  localparam int unsigned CLK_NS      = 8;
  localparam int unsigned RST_HOLD_NS = 100;
  localparam int unsigned RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] RST_HOLD_CNT = RST_HOLD_CYC[3:0];

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } rwc_bus_s;

  typedef enum logic {RS_RUN, RS_HOLD} rwc_rst_e;

endpackage : rwc_pkg

// ===== verilog/rwc_wdog.sv
// Watchdog counter stepped by the 1 kHz tick
`timescale 1ns/1ps
`default_nettype none
module rwc_wdog import rwc_pkg::*; (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            ce,
  input  wire logic            tick,
  input  wire logic            clr,
  input  wire logic            dbg_hold,
  input  wire logic            stop_mode,
  input  wire logic            enable,
  input  wire logic            long_sel,
  output logic                 timeout,
  output logic [WD_W-1:0]      count
);

  logic [WD_W-1:0] cnt_q;
  logic [WD_W-1:0] cnt_d;
  logic            to_q;
  logic            to_d;
  wire  [WD_W-1:0] limit = long_sel ? WD_LONG : WD_SHORT; // RULE8
  wire             step  = tick & enable & ~dbg_hold & ~stop_mode; // RULE9 RULE12
  wire  [WD_W-1:0] cnt_inc = cnt_q + 9'h001;

  assign to_d  = step & ~clr & (cnt_inc == limit); // RULE10
  assign cnt_d = (clr | stop_mode | to_d) ? '0 : (step ? cnt_inc : cnt_q); // RULE7 RULE13

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      to_q  <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      to_q  <= to_d;
    end
  end

  assign timeout = to_q;
  assign count   = cnt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  stop_zero_a: assert property (ce && stop_mode |=> cnt_q == '0) // RULE13
    else $error("watchdog not zero in stop");
  dbg_hold_a: assert property (ce && dbg_hold && !clr && !stop_mode |=> $stable(cnt_q)) // RULE12
    else $error("watchdog moved in debug");
  clr_zero_a: assert property (ce && clr |=> cnt_q == '0 && !to_q) // RULE7
    else $error("watchdog not cleared");
  short_to_a: assert property (ce && step && !clr && !long_sel && cnt_q == 9'h01F |=> to_q) // RULE8
    else $error("short time-out missed");

endmodule : rwc_wdog
`default_nettype wire

// ===== verilog/rwc_top.sv
// Reset source collection, cause recording, watchdog and wakeup gating
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module rwc_top import rwc_pkg::*; (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire rwc_bus_s              bus,
  output logic [DW-1:0]              rdata,
  input  wire logic                  reset_pin_n,
  input  wire logic                  por_detect,
  input  wire logic                  low_voltage_detect,
  input  wire logic                  clk_1khz,
  input  wire logic                  illegal_opcode_reset,
  input  wire logic                  illegal_address_reset,
  input  wire logic                  debug_forced_reset_cmd,
  input  wire logic                  stop_exec,
  input  wire logic                  stop_mode,
  input  wire logic                  wait_mode,
  input  wire logic                  debug_mode,
  input  wire logic [NMOD*FPM-1:0]   mod_flag,
  input  wire logic [NMOD*FPM-1:0]   mod_ien,
  output logic                       sys_reset,
  output logic                       fetch_start,
  output logic [VEC_W-1:0]           fetch_addr,
  output logic                       periph_disable,
  output logic                       pin_hiz,
  output logic                       pull_off,
  output logic                       lowvolt_run,
  output logic                       wake_req,
  output logic                       stop_allowed
);

  // Input synchronisers
  logic pin_s1_q, pin_s2_q;
  logic por_s1_q, por_s2_q;
  logic lv_s1_q, lv_s2_q;
  logic k_s1_q, k_s2_q, k_s3_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      por_s1_q <= 1'b0;
      por_s2_q <= 1'b0;
      lv_s1_q  <= 1'b0;
      lv_s2_q  <= 1'b0;
      k_s1_q   <= 1'b0;
      k_s2_q   <= 1'b0;
      k_s3_q   <= 1'b0;
    end else if (ce) begin
      pin_s1_q <= reset_pin_n;
      pin_s2_q <= pin_s1_q;
      por_s1_q <= por_detect;
      por_s2_q <= por_s1_q;
      lv_s1_q  <= low_voltage_detect;
      lv_s2_q  <= lv_s1_q;
      k_s1_q   <= clk_1khz;
      k_s2_q   <= k_s1_q;
      k_s3_q   <= k_s2_q;
    end
  end

  wire tick = k_s2_q & ~k_s3_q; // RULE9

  // Register state
  rwc_rst_e        state_q, state_d;
  logic [3:0]      hold_q, hold_d;
  logic [DW-1:0]   cause_q, cause_d;
  logic [DW-1:0]   opt_q;
  logic            opt_lock_q;
  logic [DW-1:0]   pm_q;
  logic [NMOD-1:0] pend_q;
  logic            wake_q;
  logic            fetch_q;
  logic            stop_q;
  logic [DW-1:0]   rdata_q;
  logic            wd_to;

  // Address decode
  wire wr_cause = bus.wr & (bus.addr == OFS_CAUSE);
  wire wr_opt   = bus.wr & (bus.addr == OFS_OPT);
  wire wr_pm    = bus.wr & (bus.addr == OFS_PM);
  wire opt_take = wr_opt & ~opt_lock_q; // RULE22

  // Reset sources
  wire in_hold    = (state_q == RS_HOLD);
  wire pin_rst    = opt_q[OPT_PIN] & ~pin_s2_q; // RULE5
  wire lv_on      = pm_q[PM_LVEN] & (~stop_mode | pm_q[PM_LVSE]); // RULE18
  wire lv_rst     = lv_on & pm_q[PM_LVRE] & lv_s2_q; // RULE20
  wire wd_rst     = wd_to & opt_q[OPT_WEN]; // RULE6 RULE10
  wire illegal_opcode_reset_rst   = illegal_opcode_reset | (stop_exec & ~opt_q[OPT_STOP]); // RULE23
  wire por_rst    = por_s2_q;
  wire any_rst    = por_rst | pin_rst | lv_rst | wd_rst | illegal_opcode_reset_rst |
                    illegal_address_reset | debug_forced_reset_cmd; // RULE4
  wire supply_low = por_s2_q | (lv_s2_q & cause_q[CS_LVD]); // RULE19 RULE20

  wire [DW-1:0] cause_evt = {por_rst, pin_rst, wd_rst, illegal_opcode_reset_rst,
                             illegal_address_reset, 1'b0, por_rst | lv_rst, 1'b0}; // RULE4 RULE19

  // Reset sequencing
  always_comb begin
    state_d = state_q;
    hold_d  = hold_q;
    cause_d = cause_q;
    unique case (state_q)
      RS_RUN: begin
        if (any_rst) begin
          state_d = RS_HOLD;
          hold_d  = RST_HOLD_CNT;
          cause_d = debug_forced_reset_cmd ? '0 : cause_evt; // RULE21 RULE24
        end
      end
      RS_HOLD: begin
        if (hold_q != 4'h0) begin
          hold_d = hold_q - 4'h1;
        end else if (!supply_low) begin
          state_d = RS_RUN; // RULE19 RULE20
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= RS_HOLD;
      hold_q  <= RST_HOLD_CNT;
      cause_q <= (8'h01 << CS_POR) | (8'h01 << CS_LVD); // RULE19
      fetch_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      hold_q  <= hold_d;
      cause_q <= cause_d;
      fetch_q <= in_hold & (state_d == RS_RUN); // RULE1
    end
  end

  // Option and power registers, defaults restored by every reset
  always_ff @(posedge clk) begin
    if (rst || in_hold) begin
      opt_q      <= OPT_RST; // RULE3 RULE6 RULE8
      opt_lock_q <= 1'b0;
      pm_q       <= PM_RST;
    end else if (ce) begin
      if (opt_take) begin
        opt_q      <= bus.wdata & OPT_MASK; // RULE22
        opt_lock_q <= 1'b1;
      end
      if (wr_pm) begin
        pm_q <= bus.wdata & PM_MASK;
      end
    end
  end

  // Watchdog
  rwc_wdog u_wdog (
    .clk       (clk),
    .rst       (rst | in_hold),
    .ce        (ce),
    .tick      (tick),
    .clr       (wr_cause | opt_take), // RULE7 RULE11
    .dbg_hold  (debug_mode), // RULE12
    .stop_mode (stop_mode | (stop_mode & ~stop_q)), // RULE13
    .enable    (opt_q[OPT_WEN]), // RULE6
    .long_sel  (opt_q[OPT_WPS]), // RULE8
    .timeout   (wd_to),
    .count     ()
  );

  // Wakeup pending, one bit per module
  logic [NMOD-1:0] pend_d;
  genvar gi;
  generate
    for (gi = 0; gi < NMOD; gi++) begin : g_pend
      assign pend_d[gi] = |(mod_flag[gi*FPM +: FPM] & mod_ien[gi*FPM +: FPM]); // RULE15 RULE17
    end
  endgenerate

  wire wake_d = (|pend_d) & (wait_mode | stop_mode); // RULE14

  // Read mux
  wire [DW-1:0] rd_mux = (bus.addr == OFS_CAUSE) ? cause_q :
                         (bus.addr == OFS_OPT)   ? opt_q :
                         (bus.addr == OFS_PM)    ? pm_q :
                         (bus.addr == OFS_PEND)  ? {{(DW-NMOD){1'b0}}, pend_q} : '0; // RULE16

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_q  <= '0;
      wake_q  <= 1'b0;
      stop_q  <= 1'b0;
      rdata_q <= '0;
    end else if (ce) begin
      pend_q  <= in_hold ? '0 : pend_d; // RULE16
      wake_q  <= ~in_hold & wake_d; // RULE14
      stop_q  <= stop_mode;
      rdata_q <= bus.rd ? rd_mux : '0;
    end
  end

  assign rdata          = rdata_q;
  assign sys_reset      = in_hold; // RULE3
  assign periph_disable = in_hold; // RULE3
  assign pin_hiz        = in_hold; // RULE3
  assign pull_off       = in_hold; // RULE3
  assign fetch_start    = fetch_q; // RULE1
  assign fetch_addr     = RESET_VEC; // RULE1
  assign lowvolt_run    = lv_on; // RULE18
  assign wake_req       = wake_q;
  assign stop_allowed   = opt_q[OPT_STOP];

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_second_opt;
    ce && opt_lock_q && !in_hold && wr_opt;
  endsequence

  opt_once_a: assert property (s_second_opt |=> $stable(opt_q)) // RULE22
    else $error("option register took a second write");
  cause_keep_a: assert property (ce && !in_hold && !any_rst |=> $stable(cause_q)) // RULE24
    else $error("cause flags moved outside reset");
  dbg_clear_a: assert property (ce && !in_hold && debug_forced_reset_cmd |=> cause_q == '0 && in_hold) // RULE21
    else $error("debug reset kept cause flags");
  pin_gate_a: assert property (ce && !in_hold && !opt_q[OPT_PIN] && !any_rst |=> !in_hold) // RULE5
    else $error("reset without active source");
  wd_flag_a: assert property (ce && !in_hold && wd_rst && !debug_forced_reset_cmd |=> cause_q[CS_WDOG]) // RULE10
    else $error("watchdog reset flag not set");
  illegal_opcode_reset_stop_a: assert property (ce && !in_hold && stop_exec && !opt_q[OPT_STOP] |=> in_hold) // RULE23
    else $error("disabled stop did not reset");
  hold_low_a: assert property (ce && in_hold && por_s2_q |=> in_hold) // RULE19
    else $error("left reset during power-on");
  lv_stop_a: assert property (stop_mode && !pm_q[PM_LVSE] |-> !lowvolt_run) // RULE18
    else $error("low-voltage detector on in stop");
  wake_gate_a: assert property (ce && !in_hold && (mod_flag & mod_ien) == '0 |=> !wake_q) // RULE15
    else $error("wake from gated source");
  fetch_vec_a: assert property (ce && in_hold && state_d == RS_RUN |=> fetch_start && fetch_addr == 14'h3FFD) // RULE1
    else $error("reset fetch not at vector");
  periph_off_a: assert property (in_hold |-> periph_disable && pin_hiz && pull_off) // RULE3
    else $error("peripherals live during reset");

endmodule : rwc_top
`default_nettype wire

// ===== tb/test_reset_watchdog_wakeup_control.sv
// Self-checking testbench for the reset, watchdog and wakeup control block
`timescale 1ns/1ps
`default_nettype none
module test_reset_watchdog_wakeup_control import rwc_pkg::*; ;
  logic                clk, rst, ce, reset_pin_n, por_detect, low_voltage_detect, clk_1khz;
  logic                illegal_opcode_reset, illegal_address_reset, debug_forced_reset_cmd;
  logic                stop_exec, stop_mode, wait_mode, debug_mode;
  logic                sys_reset, fetch_start, periph_disable, pin_hiz, pull_off;
  logic                lowvolt_run, wake_req, stop_allowed;
  logic [NMOD*FPM-1:0] mod_flag, mod_ien;
  logic [DW-1:0]       rdata, rv;
  logic [VEC_W-1:0]    fetch_addr;
  rwc_bus_s            bus;
  int                  n_mismatch, n_compared;

  rwc_top DUT (.clk(clk), .rst(rst), .ce(ce), .bus(bus), .rdata(rdata), .reset_pin_n(reset_pin_n),
    .por_detect(por_detect), .low_voltage_detect(low_voltage_detect), .clk_1khz(clk_1khz),
    .illegal_opcode_reset(illegal_opcode_reset), .illegal_address_reset(illegal_address_reset),
    .debug_forced_reset_cmd(debug_forced_reset_cmd), .stop_exec(stop_exec), .stop_mode(stop_mode),
    .wait_mode(wait_mode), .debug_mode(debug_mode), .mod_flag(mod_flag), .mod_ien(mod_ien),
    .sys_reset(sys_reset), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
    .periph_disable(periph_disable), .pin_hiz(pin_hiz), .pull_off(pull_off),
    .lowvolt_run(lowvolt_run), .wake_req(wake_req), .stop_allowed(stop_allowed));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rc(input string nm, input logic [AW-1:0] a, input logic [DW-1:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    rv = rdata;
    chk(nm, {8'h00, rv}, {8'h00, exp});
  endtask : rc

  // Rising edges on the 1 kHz input, sped up for simulation
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      clk_1khz <= 1'b1;
      repeat (4) @(posedge clk);
      clk_1khz <= 1'b0;
      repeat (4) @(posedge clk);
    end
    #1;
  endtask : tick

  task automatic run_up();
    int i;
    chk("in_reset", {12'h000, periph_disable, pin_hiz, pull_off, sys_reset}, 16'h000F);
    for (i = 0; i < 300 && sys_reset !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    chk("fetch", {1'b0, fetch_start, fetch_addr}, {2'b01, 14'h3FFD});
    chk("released", {13'h0000, periph_disable, pin_hiz, pull_off}, 16'h0000);
  endtask : run_up

  task automatic src(input int k, input logic [DW-1:0] exp);
    @(posedge clk);
    case (k)
      0: illegal_address_reset <= 1'b1;
      1: illegal_opcode_reset <= 1'b1;
      2: debug_forced_reset_cmd <= 1'b1;
      3: stop_exec <= 1'b1;
      default: reset_pin_n <= 1'b0;
    endcase
    @(posedge clk);
    {illegal_address_reset, illegal_opcode_reset, debug_forced_reset_cmd, stop_exec} <= 4'h0;
    repeat (5) @(posedge clk);
    reset_pin_n <= 1'b1;
    #1;
    run_up();
    rc("cause", OFS_CAUSE, exp);
  endtask : src

  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #160000;
    n_mismatch++;
    wrap_up();
  end

  initial begin
    {rst, ce, reset_pin_n, por_detect, low_voltage_detect, clk_1khz} = 6'b111000;
    {illegal_opcode_reset, illegal_address_reset, debug_forced_reset_cmd, stop_exec} = 4'h0;
    {stop_mode, wait_mode, debug_mode} = 3'b000;
    mod_flag = '0;
    mod_ien = '0;
    bus = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    run_up();
    rc("cause", OFS_CAUSE, 8'h82);
    rc("opt", OFS_OPT, 8'hC0);
    rc("pm", OFS_PM, 8'h05);
    rc("unmapped", 8'h10, 8'h00);
    tick(40);
    chk("long_default", {15'h0000, sys_reset}, 16'h0000);
    $display("test defaults done");

    wr(OFS_OPT, 8'h00);
    wr(OFS_OPT, 8'hE1);
    rc("opt_once", OFS_OPT, 8'h00);
    chk("stop_off", {15'h0000, stop_allowed}, 16'h0000);
    tick(40);
    chk("wdog_off", {15'h0000, sys_reset}, 16'h0000);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    cyc(8);
    chk("pin_off", {15'h0000, sys_reset}, 16'h0000);
    reset_pin_n <= 1'b1;
    $display("test option done");

    @(posedge clk);
    wait_mode <= 1'b1;
    mod_flag <= 10'h004;
    cyc(3);
    chk("wake_gated", {15'h0000, wake_req}, 16'h0000);
    @(posedge clk);
    mod_ien <= 10'h00C;
    cyc(3);
    chk("wake", {15'h0000, wake_req}, 16'h0001);
    wr(OFS_PEND, 8'h00);
    rc("pend", OFS_PEND, 8'h02);
    @(posedge clk);
    mod_flag <= 10'h00C;
    wait_mode <= 1'b0;
    cyc(3);
    chk("no_wait", {15'h0000, wake_req}, 16'h0000);
    @(posedge clk);
    mod_flag <= 10'h008;
    rc("pend_one", OFS_PEND, 8'h02);
    @(posedge clk);
    mod_flag <= 10'h000;
    rc("pend_clr", OFS_PEND, 8'h00);
    @(posedge clk);
    stop_mode <= 1'b1;
    cyc(2);
    chk("lv_stop", {15'h0000, lowvolt_run}, 16'h0000);
    wr(OFS_PM, 8'h07);
    cyc(2);
    chk("lv_stop_en", {15'h0000, lowvolt_run}, 16'h0001);
    mod_flag <= 10'h008;
    cyc(3);
    chk("wake_stop", {15'h0000, wake_req}, 16'h0001);
    mod_flag <= 10'h000;
    stop_mode <= 1'b0;
    $display("test wake done");

    src(0, 8'h08);
    rc("opt_back", OFS_OPT, 8'hC0);
    src(3, 8'h10);
    src(1, 8'h10);
    src(2, 8'h00);
    wr(OFS_OPT, 8'h01);
    src(4, 8'h40);
    $display("test sources done");

    tick(20);
    wr(OFS_OPT, 8'h80);
    tick(31);
    chk("opt_clear", {15'h0000, sys_reset}, 16'h0000);
    wr(OFS_CAUSE, 8'hFF);
    rc("cause_kept", OFS_CAUSE, 8'h40);
    tick(31);
    chk("cause_clear", {15'h0000, sys_reset}, 16'h0000);
    @(posedge clk);
    debug_mode <= 1'b1;
    tick(40);
    chk("dbg_hold", {15'h0000, sys_reset}, 16'h0000);
    debug_mode <= 1'b0;
    stop_mode <= 1'b1;
    tick(3);
    stop_mode <= 1'b0;
    tick(31);
    chk("stop_zero", {15'h0000, sys_reset}, 16'h0000);
    tick(1);
    chk("short_out", {15'h0000, sys_reset}, 16'h0001);
    run_up();
    rc("wd_cause", OFS_CAUSE, 8'h20);
    $display("test watchdog done");

    @(posedge clk);
    low_voltage_detect <= 1'b1;
    cyc(40);
    chk("lv_hold", {15'h0000, sys_reset}, 16'h0001);
    low_voltage_detect <= 1'b0;
    run_up();
    rc("lv_cause", OFS_CAUSE, 8'h02);
    @(posedge clk);
    por_detect <= 1'b1;
    low_voltage_detect <= 1'b1;
    cyc(20);
    por_detect <= 1'b0;
    cyc(40);
    chk("por_hold", {15'h0000, sys_reset}, 16'h0001);
    low_voltage_detect <= 1'b0;
    run_up();
    rc("por_cause", OFS_CAUSE, 8'h82);
    $display("test supply done");

    @(posedge clk);
    ce <= 1'b0;
    wr(OFS_PM, 8'h00);
    @(posedge clk);
    ce <= 1'b1;
    rc("ce_freeze", OFS_PM, 8'h05);
    $display("test enable done");
    wrap_up();
  end
endmodule : test_reset_watchdog_wakeup_control
`default_nettype wire
